// ===== src/plbd_pkg.sv
/*
 * Shared constants, types and helper functions of the loopback, self-test
 * and cable-diagnostic block.
 * Assumes one clock domain and a 16-bit management register space.
 */
package plbd_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [15:0] OFS_BASIC_MODE_CONTROL = 16'h0000;
    localparam logic [15:0] OFS_CONFIG_ONE         = 16'h0009;
    localparam logic [15:0] OFS_SELF_TEST_CONTROL  = 16'h0016;
    localparam logic [15:0] OFS_SECOND_STATUS      = 16'h0017;
    localparam logic [15:0] OFS_RECEIVED_BYTE_CNT  = 16'h0071;
    localparam logic [15:0] OFS_ERROR_BYTE_CNT     = 16'h0072;
    localparam logic [15:0] OFS_LOOPBACK_TUNING    = 16'h00FE;
    localparam logic [15:0] OFS_REFL_CONTROL       = 16'h0180;
    localparam logic [15:0] OFS_REFL_RESULT0       = 16'h0190;

    // ==========================================================
    // Field positions
    localparam int BMC_LOOP_BIT    = 14;  // MAC-side loopback
    localparam int CONFIG_ONE_AUTO_DIAG  = 7;   // Reflectometry on link loss
    localparam int STC_RUN_BIT     = 15;  // Self-test run
    localparam int STC_CONT_BIT    = 14;  // Counters wrap instead of hold
    localparam int STC_LONG_BIT    = 13;  // 1518-byte packets
    localparam int STC_GAP_LSB     = 8;   // Gap field, 4 bits
    localparam int STC_REVMAC_BIT  = 6;   // Reverse loop also to MAC
    localparam int STC_MACLINE_BIT = 5;   // MAC loop also to line
    localparam int STC_REV_BIT     = 4;
    localparam int STC_EXT_BIT     = 3;
    localparam int STC_ANA_BIT     = 2;
    localparam int STC_DIG_BIT     = 1;
    localparam int STC_PCS_BIT     = 0;
    localparam int RFC_START_BIT   = 0;

    // ==========================================================
    // Reset values
    localparam logic [15:0] RST_BASIC_MODE_CONTROL = 16'h0000;
    localparam logic [15:0] RST_CONFIG_ONE         = 16'h0000;
    localparam logic [15:0] RST_SELF_TEST_CONTROL  = 16'h0000;
    localparam logic [15:0] RST_LOOPBACK_TUNING    = 16'h0000;

    // ==========================================================
    // Counts
    localparam logic [10:0] PKT_LEN_SHORT = 11'h040;  // 64 bytes
    localparam logic [10:0] PKT_LEN_LONG  = 11'h5EE;  // 1518 bytes
    localparam logic [7:0]  GAP_BASE      = 8'h0C;
    localparam logic [3:0]  LOCK_MATCHES  = 4'h4;
    localparam logic [3:0]  LOSS_MISSES   = 4'h4;
    localparam logic [2:0]  MAX_REFL      = 3'h5;
    localparam logic [14:0] PRBS_SEED     = 15'h7FFF;
    localparam logic [15:0] CNT_MAX       = 16'hFFFF;
    localparam logic [1:0]  SPD_10        = 2'h0;
    localparam logic [1:0]  SPD_100       = 2'h1;
    localparam logic [1:0]  SPD_1000      = 2'h2;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        LB_NONE = 3'b000, LB_MAC = 3'b001, LB_PCS = 3'b010, LB_DIG = 3'b011,
        LB_ANA  = 3'b100, LB_EXT = 3'b101, LB_REV = 3'b110
    } plbd_loop_type;

    typedef enum logic [1:0] {
        GEN_IDLE = 2'b00, GEN_PKT = 2'b01, GEN_GAP = 2'b10
    } plbd_gen_type;

    // Eight steps of x^15+x^14+1; new byte lands in the low bits
    function automatic logic [14:0] plbd_adv8(input logic [14:0] s);
        logic [14:0] t;
        t = s;
        for (int i = 0; i < 8; i++)
        begin
            t = {t[13:0], t[14] ^ t[13]};
        end
        return t;
    endfunction : plbd_adv8

    // Counter step: wrap when continuous, else hold at the top
    function automatic logic [15:0] plbd_cnt(input logic [15:0] c, input logic inc,
                                             input logic cont);
        if (!inc)
            return c;
        else if (c == CNT_MAX)
            return cont ? 16'h0000 : CNT_MAX;
        else
            return c + 16'h0001;
    endfunction : plbd_cnt

endpackage : plbd_pkg

// ===== src/plbd_top.sv
/*
 * Loopback selection, PRBS packet generator and checker, and reflection
 * recorder of a tri-speed transceiver, behind a simple management port.
 * Assumes all inputs are produced on core_clk by the surrounding PHY core.
 */
// Behaviour
// RULE_01: MAC-side loop only via basic control bit
// RULE_02: Other loops enabled by self-test control fields
// RULE_03: Link report depends on loop mode, speed
// RULE_04: External loop only at 10/100 speed
// RULE_05: Host programs tuning register before loopback
// RULE_06: Host disables autonegotiation before near loops
// RULE_07: Host forces crossover mapping before near loops
// RULE_08: MAC loop returns data; optionally also line
// RULE_09: Coding loop turns data, no processing
// RULE_10: Digital loop turns data before analog
// RULE_11: Reverse loop returns line data to partner
// RULE_12: Reverse ignores MAC; optionally feeds MAC
// RULE_13: Generator sends packets and gaps, host-set
// RULE_14: PRBS15 generator, independent self-locking checker
// RULE_15: Mismatched received bytes counted as errors
// RULE_16: Status shows lock, sync lost, busy
// RULE_17: Every received byte is counted
// RULE_18: Continuous mode counters wrap to zero
// RULE_19: One bit picks 64 or 1518 bytes
// RULE_20: Keep first five reflections per pair
// RULE_21: Cross fault kept plus four reflections
// RULE_22: Auto reflectometry on link drop, readable
// RULE_23: Otherwise counters hold at their maximum
module plbd_top
    import plbd_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [15:0] mgmt_addr,      // Register offset
    input  wire logic        mgmt_wr,        // Write strobe
    input  wire logic        mgmt_rd,        // Read strobe
    input  wire logic [15:0] mgmt_wdata,
    output logic      [15:0] mgmt_rdata,
    output logic             mgmt_rvalid,
    input  wire logic [1:0]  speed,          // Resolved speed
    input  wire logic        phy_link,       // Link from the receive chain
    input  wire logic [7:0]  mac_tx_data,
    input  wire logic        mac_tx_en,
    output logic      [7:0]  mac_rx_data,
    output logic             mac_rx_dv,
    output logic      [7:0]  line_tx_data,   // Towards coding and analog
    output logic             line_tx_en,
    input  wire logic [7:0]  line_rx_data,   // From the receiver
    input  wire logic        line_rx_dv,
    output logic             afe_loop_en,    // Analog path turned inside
    output logic             link_status,
    input  wire logic        refl_valid,     // One reflection measured
    input  wire logic        refl_cross,
    input  wire logic [14:0] refl_time,
    input  wire logic        refl_done,      // Pulse engine finished
    output logic             refl_start
);

    // ==========================================================
    // Registers and status
    logic [15:0]   bmc_r, config_one_r, stc_r, tune_r;  // Software controls
    logic [15:0]   rx_cnt_r, err_cnt_r;           // Self-test counters
    logic          run_d_r, link_d_r;             // Edge history
    logic          locked_r, sync_lost_r;
    logic [3:0]    match_run_r, miss_run_r;
    logic [14:0]   chk_state_r;                   // Checker's own LFSR
    logic [7:0]    prev_rx_r;
    plbd_gen_type  gen_state_r;
    logic [14:0]   gen_lfsr_r;
    logic [10:0]   gen_cnt_r;
    logic          refl_busy_r, refl_dn_r, cross_seen_r;
    logic [2:0]    refl_cnt_r;
    logic [15:0]   refl_slot_r [5];               // {cross, time}
    logic [7:0]    mac_rx_data_r, line_tx_data_r;
    logic          mac_rx_dv_r, line_tx_en_r, link_r;

    // ==========================================================
    // Loop mode decode, MAC loop highest priority
    wire logic    mac_lp  = bmc_r[BMC_LOOP_BIT];                      // RULE_01
    wire logic    pcs_ok  = stc_r[STC_PCS_BIT] && (speed != SPD_10);  // RULE_02
    wire logic    ext_ok  = stc_r[STC_EXT_BIT] && (speed != SPD_1000); // RULE_04
    wire plbd_loop_type loop_mode =
        mac_lp               ? LB_MAC :
        pcs_ok               ? LB_PCS :
        stc_r[STC_DIG_BIT]   ? LB_DIG :
        stc_r[STC_ANA_BIT]   ? LB_ANA :
        ext_ok               ? LB_EXT :
        stc_r[STC_REV_BIT]   ? LB_REV : LB_NONE;

    // Link report per mode and speed
    function automatic logic link_rep(input plbd_loop_type m, input logic [1:0] s,
                                      input logic l);
        unique case (m)
            LB_MAC:  return 1'b0;                  // Never reports link
            LB_PCS:  return s == SPD_100;          // Only at 100M
            LB_DIG,
            LB_ANA:  return 1'b1;                  // All speeds
            LB_EXT,
            LB_NONE,
            LB_REV:  return l;
            default: return 1'b0;                  // Unused code
        endcase
    endfunction : link_rep

    // ==========================================================
    // Data path steering
    wire logic       bist_run = stc_r[STC_RUN_BIT];
    wire logic       restart  = bist_run && !run_d_r;
    wire logic       gen_en   = (gen_state_r == GEN_PKT);
    wire logic [7:0] gen_byte = gen_lfsr_r[7:0];
    wire logic [7:0] src_data = bist_run ? gen_byte : mac_tx_data;
    wire logic       src_en   = bist_run ? gen_en : mac_tx_en;
    // Internal turnarounds: MAC side, coding layer, before analog
    wire logic inner_lp = (loop_mode == LB_MAC) || (loop_mode == LB_PCS)
                       || (loop_mode == LB_DIG);                       // RULE_09 RULE_10
    wire logic       is_rev   = (loop_mode == LB_REV);
    wire logic [7:0] rxp_data = inner_lp ? src_data : line_rx_data;
    wire logic       rxp_dv   = inner_lp ? src_en : line_rx_dv;
    // Line gets data unless the loop turns before it; the MAC loop with its line bit set still drives it
    wire logic line_drv = !inner_lp || ((loop_mode == LB_MAC) && stc_r[STC_MACLINE_BIT]); // RULE_08
    wire logic mac_feed = !is_rev || stc_r[STC_REVMAC_BIT];             // RULE_12

    // Registered data outputs; reverse loop drops MAC transmit entirely
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            line_tx_data_r <= 8'h00;
            line_tx_en_r   <= 1'b0;
            mac_rx_data_r  <= 8'h00;
            mac_rx_dv_r    <= 1'b0;
            link_r         <= 1'b0;
        end
        else
        begin
            line_tx_data_r <= is_rev ? line_rx_data : src_data;        // RULE_11
            line_tx_en_r   <= is_rev ? line_rx_dv : (src_en && line_drv);
            mac_rx_data_r  <= rxp_data;
            mac_rx_dv_r    <= rxp_dv && mac_feed;                       // RULE_08
            link_r         <= link_rep(loop_mode, speed, phy_link);    // RULE_03
        end
    end

    // ==========================================================
    // Packet generator: PRBS packets then idle gaps
    wire logic [10:0] pkt_len = stc_r[STC_LONG_BIT] ? PKT_LEN_LONG : PKT_LEN_SHORT; // RULE_19
    wire logic [10:0] gap_len = {3'h0, GAP_BASE + {2'h0, stc_r[STC_GAP_LSB +: 4], 2'h0}};

    always_ff @(posedge core_clk)
    begin
        if (!reset_n || !bist_run)
        begin
            gen_state_r <= GEN_IDLE;
            gen_lfsr_r  <= PRBS_SEED;
            gen_cnt_r   <= 11'h000;
        end
        else
        begin
            unique case (gen_state_r)
                GEN_IDLE:
                begin
                    gen_state_r <= GEN_PKT;
                    gen_lfsr_r  <= plbd_adv8(gen_lfsr_r);              // RULE_14
                end
                GEN_PKT:
                begin
                    gen_lfsr_r <= plbd_adv8(gen_lfsr_r);
                    gen_cnt_r  <= gen_cnt_r + 11'h001;
                    if (gen_cnt_r == pkt_len - 11'h001)
                    begin
                        gen_state_r <= GEN_GAP;                         // RULE_13
                        gen_cnt_r   <= 11'h000;
                    end
                end
                GEN_GAP:
                begin
                    gen_cnt_r <= gen_cnt_r + 11'h001;
                    if (gen_cnt_r == gap_len - 11'h001)
                    begin
                        gen_state_r <= GEN_PKT;
                        gen_cnt_r   <= 11'h000;
                    end
                end
                default: gen_state_r <= GEN_IDLE;                       // Unused code
            endcase
        end
    end

    // ==========================================================
    // Checker: loads from the stream until it predicts four bytes
    wire logic        chk_v    = rxp_dv && bist_run;
    wire logic [14:0] chk_next = plbd_adv8(chk_state_r);
    wire logic        chk_hit  = (rxp_data == chk_next[7:0]);
    wire logic        chk_err  = chk_v && locked_r && !chk_hit;
    wire logic        cont     = stc_r[STC_CONT_BIT];

    always_ff @(posedge core_clk)
    begin
        if (!reset_n || restart)
        begin
            chk_state_r <= 15'h0000;
            prev_rx_r   <= 8'h00;
            locked_r    <= 1'b0;
            sync_lost_r <= 1'b0;
            match_run_r <= 4'h0;
            miss_run_r  <= 4'h0;
            rx_cnt_r    <= 16'h0000;
            err_cnt_r   <= 16'h0000;
        end
        else
        begin
            rx_cnt_r  <= plbd_cnt(rx_cnt_r, chk_v, cont);              // RULE_17 RULE_18 RULE_23
            err_cnt_r <= plbd_cnt(err_cnt_r, chk_err, cont);           // RULE_15
            if (chk_v)
            begin
                prev_rx_r <= rxp_data;
                if (!locked_r)
                begin
                    // Self-synchronise: state is the last fifteen bits seen
                    chk_state_r <= {prev_rx_r[6:0], rxp_data};
                    match_run_r <= chk_hit ? match_run_r + 4'h1 : 4'h0;
                    locked_r    <= chk_hit && (match_run_r == LOCK_MATCHES - 4'h1); // RULE_16
                    miss_run_r  <= 4'h0;
                end
                else
                begin
                    chk_state_r <= chk_next;
                    miss_run_r  <= chk_hit ? 4'h0 : miss_run_r + 4'h1;
                    if (!chk_hit && (miss_run_r == LOSS_MISSES - 4'h1))
                    begin
                        locked_r    <= 1'b0;
                        sync_lost_r <= 1'b1;                            // RULE_16
                        match_run_r <= 4'h0;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Reflection recorder; a run on link loss needs the diag bit
    wire logic       rfc_hit  = mgmt_wr && (mgmt_addr == OFS_REFL_CONTROL);
    wire logic       link_drop = link_d_r && !phy_link && config_one_r[CONFIG_ONE_AUTO_DIAG];
    wire logic       go       = !refl_busy_r && ((rfc_hit && mgmt_wdata[RFC_START_BIT])
                                              || link_drop);            // RULE_22
    wire logic       rv       = refl_valid && refl_busy_r;
    wire logic       wr_norm  = rv && !refl_cross && (refl_cnt_r < MAX_REFL); // RULE_20
    wire logic       wr_cross = rv && refl_cross && !cross_seen_r;     // RULE_21
    // A late cross fault takes the fifth slot so four normal ones remain
    wire logic [2:0] wr_idx   = (wr_cross && refl_cnt_r == MAX_REFL) ? MAX_REFL - 3'h1
                                                                      : refl_cnt_r;

    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            refl_busy_r  <= 1'b0;
            refl_dn_r    <= 1'b0;
            cross_seen_r <= 1'b0;
            refl_cnt_r   <= 3'h0;
            refl_start   <= 1'b0;
            link_d_r     <= 1'b0;
        end
        else
        begin
            link_d_r   <= phy_link;
            refl_start <= go;
            if (go)
            begin
                refl_busy_r  <= 1'b1;
                refl_dn_r    <= 1'b0;
                cross_seen_r <= 1'b0;
                refl_cnt_r   <= 3'h0;
            end
            else if (refl_busy_r)
            begin
                if (refl_done)
                begin
                    refl_busy_r <= 1'b0;
                    refl_dn_r   <= 1'b1;
                end
                if (wr_cross)
                    cross_seen_r <= 1'b1;
                if (wr_norm || (wr_cross && refl_cnt_r < MAX_REFL))
                    refl_cnt_r <= refl_cnt_r + 3'h1;
            end
        end
    end

    // Slots survive until the next run so software reads them any time
    for (genvar g = 0; g < 5; g++)
    begin : g_slot
        always_ff @(posedge core_clk)
        begin
            if (!reset_n)
                refl_slot_r[g] <= 16'h0000;
            else if ((wr_norm || wr_cross) && wr_idx == 3'(g))
                refl_slot_r[g] <= {refl_cross, refl_time};              // RULE_20
        end
    end

    // ==========================================================
    // Management registers
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            bmc_r   <= RST_BASIC_MODE_CONTROL;
            config_one_r  <= RST_CONFIG_ONE;
            stc_r   <= RST_SELF_TEST_CONTROL;
            tune_r  <= RST_LOOPBACK_TUNING;
            run_d_r <= 1'b0;
        end
        else
        begin
            run_d_r <= bist_run;
            if (mgmt_wr && mgmt_addr == OFS_BASIC_MODE_CONTROL) bmc_r  <= mgmt_wdata; // RULE_01
            if (mgmt_wr && mgmt_addr == OFS_CONFIG_ONE)         config_one_r <= mgmt_wdata;
            if (mgmt_wr && mgmt_addr == OFS_SELF_TEST_CONTROL)  stc_r  <= mgmt_wdata; // RULE_02
            if (mgmt_wr && mgmt_addr == OFS_LOOPBACK_TUNING)    tune_r <= mgmt_wdata;
        end
    end

    wire logic [15:0] ridx = mgmt_addr - OFS_REFL_RESULT0;
    wire logic [15:0] rd_mux =
        (mgmt_addr == OFS_BASIC_MODE_CONTROL) ? bmc_r :
        (mgmt_addr == OFS_CONFIG_ONE)         ? config_one_r :
        (mgmt_addr == OFS_SELF_TEST_CONTROL)  ? stc_r :
        (mgmt_addr == OFS_SECOND_STATUS)      ? {13'h0000, gen_state_r != GEN_IDLE,
                                                 sync_lost_r, locked_r} :
        (mgmt_addr == OFS_RECEIVED_BYTE_CNT)  ? rx_cnt_r :
        (mgmt_addr == OFS_ERROR_BYTE_CNT)     ? err_cnt_r :
        (mgmt_addr == OFS_LOOPBACK_TUNING)    ? tune_r :
        (mgmt_addr == OFS_REFL_CONTROL)       ? {9'h000, refl_cnt_r, 2'h0, refl_dn_r,
                                                 refl_busy_r} :
        (ridx < 16'h0005)                     ? refl_slot_r[ridx[2:0]] : 16'h0000;

    // Read data is held until the next read
    always_ff @(posedge core_clk)
    begin
        if (!reset_n)
        begin
            mgmt_rdata  <= 16'h0000;
            mgmt_rvalid <= 1'b0;
        end
        else
        begin
            mgmt_rvalid <= mgmt_rd;
            if (mgmt_rd)
                mgmt_rdata <= rd_mux;
        end
    end

    assign mac_rx_data  = mac_rx_data_r;
    assign mac_rx_dv    = mac_rx_dv_r;
    assign line_tx_data = line_tx_data_r;
    assign line_tx_en   = line_tx_en_r;
    assign link_status  = link_r;
    assign afe_loop_en  = (loop_mode == LB_ANA);

    // ==========================================================
    // Assertions
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    sequence s_miss_top;
        chk_err && err_cnt_r == CNT_MAX && !restart;
    endsequence
    property p_mac_mode;  (loop_mode == LB_MAC) == mac_lp; endproperty
    a_mac_mode: assert property (p_mac_mode) else $error("mac loop mode mismatch"); // RULE_01
    property p_link;  (loop_mode == LB_MAC) || (loop_mode == LB_PCS && speed == SPD_10)
                      |=> !link_status; endproperty
    a_link: assert property (p_link) else $error("link reported in loop"); // RULE_03
    property p_ext;  speed == SPD_1000 |-> loop_mode != LB_EXT; endproperty
    a_ext: assert property (p_ext) else $error("external loop at gigabit"); // RULE_04
    property p_mac_lp;  loop_mode == LB_MAC && !stc_r[STC_MACLINE_BIT] && !bist_run
        |=> !line_tx_en && mac_rx_dv == $past(mac_tx_en); endproperty
    a_mac_lp: assert property (p_mac_lp) else $error("mac loop path wrong"); // RULE_08
    property p_rev;  is_rev |=> line_tx_data == $past(line_rx_data)
        && line_tx_en == $past(line_rx_dv); endproperty
    a_rev: assert property (p_rev) else $error("reverse loop path wrong"); // RULE_11
    property p_rev_mac;  is_rev && !stc_r[STC_REVMAC_BIT] |=> !mac_rx_dv; endproperty
    a_rev_mac: assert property (p_rev_mac) else $error("reverse leaks to mac"); // RULE_12
    property p_pkt;  gen_en && gen_cnt_r == pkt_len - 11'h001 && bist_run
        ##1 bist_run |-> gen_state_r == GEN_GAP; endproperty
    a_pkt: assert property (p_pkt) else $error("packet length wrong"); // RULE_19
    property p_wrap;  (s_miss_top and cont) |=> err_cnt_r == 16'h0000; endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap"); // RULE_18
    property p_hold;  (s_miss_top and !cont) |=> err_cnt_r == CNT_MAX; endproperty
    a_hold: assert property (p_hold) else $error("counter did not hold"); // RULE_23
    property p_err;  chk_err && err_cnt_r != CNT_MAX && !restart
        |=> err_cnt_r == $past(err_cnt_r) + 16'h0001; endproperty
    a_err: assert property (p_err) else $error("error byte not counted"); // RULE_15
    property p_refl_max;  refl_cnt_r <= MAX_REFL; endproperty
    a_refl_max: assert property (p_refl_max) else $error("too many reflections"); // RULE_20
    property p_auto;  link_drop && !refl_busy_r |=> refl_start ##1 !refl_start; endproperty
    a_auto: assert property (p_auto) else $error("no run on link drop"); // RULE_22

endmodule : plbd_top

// ===== tb/plbd_link_partner.sv
/* Link partner model: sends a counting byte stream towards the receiver.
   Assumes the bench clocks it with core_clk and raises send to talk. */
module plbd_link_partner
(
    input  wire logic       core_clk,
    input  wire logic       send,
    output logic      [7:0] line_rx_data,
    output logic            line_rx_dv
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Stream source; idle data is inverted so a stale byte never repeats
    initial line_rx_data = 8'h10;
    initial line_rx_dv = 1'b0;
    always @(negedge core_clk)
    begin
        line_rx_dv   <= send;
        line_rx_data <= send ? line_rx_data + 8'h01 : ~line_rx_data;
    end
endmodule : plbd_link_partner

// ===== tb/phy_loopback_bist_diag_tb_top.sv
/* Bench of the loopback, self-test and diagnostic block.
   Assumes inputs change on the falling edge of core_clk only. */
module phy_loopback_bist_diag_tb_top import plbd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        core_clk, reset_n, mgmt_wr, mgmt_rd, mgmt_rvalid, send, phy_link;
    logic [15:0] mgmt_addr, mgmt_wdata, mgmt_rdata, rd_val;
    logic [1:0]  speed;
    logic [7:0]  mac_tx_data, mac_rx_data, line_tx_data, line_rx_data, prev;
    logic        mac_tx_en, mac_rx_dv, line_tx_en, line_rx_dv, afe_loop_en, link_status;
    int          err_total, cmp_count;
    // ==========================================================
    // Clock, and the two parties around the block
    initial begin core_clk = 0; forever #4 core_clk = ~core_clk; end
    plbd_link_partner i_plbd_link_partner(.core_clk(core_clk), .send(send),
        .line_rx_data(line_rx_data), .line_rx_dv(line_rx_dv));
    plbd_top i_plbd_top(.core_clk(core_clk), .reset_n(reset_n), .mgmt_addr(mgmt_addr),
        .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
        .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .speed(speed),
        .phy_link(phy_link), .mac_tx_data(mac_tx_data), .mac_tx_en(mac_tx_en),
        .mac_rx_data(mac_rx_data), .mac_rx_dv(mac_rx_dv), .line_tx_data(line_tx_data),
        .line_tx_en(line_tx_en), .line_rx_data(line_rx_data), .line_rx_dv(line_rx_dv),
        .afe_loop_en(afe_loop_en), .link_status(link_status), .refl_valid(1'b0),
        .refl_cross(1'b0), .refl_time(15'h0000), .refl_done(1'b0), .refl_start());
    // ==========================================================
    // Shared tasks
    task automatic check(input string what, input logic [15:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic wr(input logic [15:0] a, d);
        @(negedge core_clk) {mgmt_wr, mgmt_addr, mgmt_wdata} = {1'b1, a, d};
        @(negedge core_clk) mgmt_wr = 1'b0;
    endtask : wr
    // Read waits a bounded time for the one-cycle valid pulse
    task automatic rd(input logic [15:0] a);
        @(negedge core_clk) {mgmt_rd, mgmt_addr} = {1'b1, a};
        for (int i = 0; i < 4; i++)
        begin
            @(negedge core_clk) mgmt_rd = 1'b0;
            if (mgmt_rvalid === 1'b1) begin rd_val = mgmt_rdata; return; end
        end
        err_total++;
        give_verdict();
    endtask : rd
    // ==========================================================
    // Scenarios
    task automatic sc_regs;
        rd(OFS_BASIC_MODE_CONTROL); check("bmc_reset", rd_val, RST_BASIC_MODE_CONTROL);
        wr(OFS_LOOPBACK_TUNING, 16'hE720);
        rd(OFS_LOOPBACK_TUNING); check("tuning", rd_val, 16'hE720);
        rd(16'h0123); check("unmapped", rd_val, 16'h0000);
    endtask : sc_regs
    task automatic sc_mac_loop;
        phy_link = 1'b1;
        wr(OFS_BASIC_MODE_CONTROL, 16'h4000);
        @(negedge core_clk) {mac_tx_en, mac_tx_data} = {1'b1, 8'hA5};
        @(negedge core_clk) mac_tx_en = 1'b0;
        check("mac_rx", {mac_rx_dv, mac_rx_data}, 16'h01A5);
        check("line_quiet", line_tx_en, 1'b0);
        check("mac_link", link_status, 1'b0);
        wr(OFS_BASIC_MODE_CONTROL, 16'h0000);
    endtask : sc_mac_loop
    task automatic sc_reverse;
        wr(OFS_SELF_TEST_CONTROL, 16'h0010);
        {send, mac_tx_en, mac_tx_data} = {1'b1, 1'b1, 8'h5A};
        repeat (3) @(negedge core_clk);
        @(posedge core_clk) prev = line_rx_data;
        @(negedge core_clk) check("rev_tx", line_tx_data, prev);
        check("rev_mac_off", mac_rx_dv, 1'b0);
        wr(OFS_SELF_TEST_CONTROL, 16'h0050);
        @(negedge core_clk) check("rev_mac_on", mac_rx_dv, 1'b1);
        {send, mac_tx_en} = 2'b00;
    endtask : sc_reverse
    // Link report per loop mode and speed, table driven
    task automatic sc_link;
        logic [15:0] mode [4] = '{16'h0002, 16'h0001, 16'h0001, 16'h0004};
        logic [1:0]  spd  [4] = '{SPD_10, SPD_100, SPD_1000, SPD_1000};
        logic        exp  [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
        for (int i = 0; i < 4; i++)
        begin
            speed = spd[i];
            wr(OFS_SELF_TEST_CONTROL, mode[i]);
            repeat (2) @(negedge core_clk);
            check("link", link_status, exp[i]);
        end
        check("afe_loop", afe_loop_en, 1'b1);
        wr(OFS_CONFIG_ONE, 16'h0080);
        phy_link = 1'b0;
        rd(OFS_REFL_CONTROL); check("auto_refl", rd_val[0], 1'b1);
    endtask : sc_link
    task automatic sc_bist;
        rd_val = 16'h0000;
        wr(OFS_SELF_TEST_CONTROL, 16'h8002);
        for (int i = 0; i < 300 && rd_val[0] !== 1'b1; i++) rd(OFS_SECOND_STATUS);
        check("status", rd_val[2:0], 3'h5);
        rd(OFS_ERROR_BYTE_CNT); check("err_bytes", rd_val, 16'h0000);
        rd(OFS_RECEIVED_BYTE_CNT); check("rx_bytes", rd_val != 0, 1'b1);
        repeat (200) @(negedge core_clk);
        rd(OFS_ERROR_BYTE_CNT); check("err_gap", rd_val, 16'h0000);
        wr(OFS_SELF_TEST_CONTROL, 16'h8004);
        send = 1'b1;
        repeat (40) @(negedge core_clk);
        send = 1'b0;
        rd(OFS_SECOND_STATUS); check("sync_lost", rd_val[1:0], 2'h2);
        rd(OFS_ERROR_BYTE_CNT); check("err_count", rd_val >= 16'h0004, 1'b1);
    endtask : sc_bist
    // ==========================================================
    // Main sequence
    initial
    begin
        {reset_n, mgmt_wr, mgmt_rd, mgmt_addr, mgmt_wdata, send, phy_link} = '0;
        {speed, mac_tx_data, mac_tx_en, err_total, cmp_count, rd_val} = '0;
        repeat (2) @(negedge core_clk);
        reset_n = 1'b1;
        sc_regs();
        sc_mac_loop();
        sc_reverse();
        sc_link();
        sc_bist();
        give_verdict();
    end
endmodule : phy_loopback_bist_diag_tb_top
